// *** rtl/ctotr_bank.sv ***
// Timing and offset trim register bank for the two sampling cores
`timescale 1ns/100ps
`include "ctotr_cfg.svh"
// Functional notes
// - Core two single-mode timing, per input
// - Core one single-mode second-input timing trim
// - Core one dual first-input offset, reserved top
// - Core one dual second-input offset trim
// - Core one single first-input offset trim
// - Core one second-input ninety-degree offset trim
// - Core two first-input offset, any mode
// - Defaults loaded from fuses, software read/write
// - Timing trims shift sampling instant, adjustable
module ctotr_bank
(
	input  wire logic                    clock_i,
	input  wire logic                    rst_b_i,
	input  wire logic [`CTOTR_ADDR_W-1:0] reg_addr_i,
	input  wire logic                    reg_wr_i,
	input  wire ctotr_pkg::ctotr_byte_t  reg_wdata_i,
	input  wire logic                    reg_rd_i,
	output ctotr_pkg::ctotr_byte_t       reg_rdata_o,
	output logic                         reg_rvalid_o,
	input  wire ctotr_pkg::ctotr_byte_t  fuse_data_i,
	output logic [3:0]                   fuse_addr_o,
	output logic                         fuse_busy_o,
	input  wire logic                    dual_mode_i,
	input  wire logic                    fg_cal_en_i,
	input  wire logic                    core_one_in2_i,
	input  wire logic                    core_two_in2_i,
	output ctotr_pkg::ctotr_byte_t       core_one_timing_o,
	output ctotr_pkg::ctotr_byte_t       core_two_timing_o,
	output logic [`CTOTR_OFFSET_MSB:0]   core_one_offset_o,
	output logic [`CTOTR_OFFSET_MSB:0]   core_two_offset_o
);
	import ctotr_pkg::*;

	typedef struct packed {
		logic [`CTOTR_FUSE_BYTES-1:0][7:0] mem;
		ctotr_byte_t                       rdata;
		logic                              rvalid;
		logic                              busy;
		ctotr_byte_t                       t1;
		ctotr_byte_t                       t2;
		logic [`CTOTR_OFFSET_MSB:0]        o1;
		logic [`CTOTR_OFFSET_MSB:0]        o2;
	} ctotr_bank_t;

	ctotr_bank_t s;
	ctotr_bank_t next_s;

	logic        ld_we;
	ctotr_idx_t  ld_idx;
	ctotr_byte_t ld_data;
	logic        ld_busy;

	ctotr_fuse_loader u_loader
	(
		.clock_i     (clock_i),
		.rst_b_i     (rst_b_i),
		.fuse_data_i (fuse_data_i),
		.fuse_addr_o (fuse_addr_o),
		.ld_we_o     (ld_we),
		.ld_idx_o    (ld_idx),
		.ld_data_o   (ld_data),
		.busy_o      (ld_busy)
	);

	// Byte address to storage index; bit 4 flags a mapped address
	function automatic logic [4:0] map_addr(input logic [`CTOTR_ADDR_W-1:0] a);
		logic [4:0]               r;
		logic [`CTOTR_ADDR_W-1:0] even;
		r = 5'h00;
		// Both bytes of an offset pair share the even address
		even = {a[`CTOTR_ADDR_W-1:1], 1'b0};
		if (a == `CTOTR_ADDR_T2_SINGLE_IN1)
		begin
			r = {1'b1, `CTOTR_IDX_T2_SINGLE_IN1};
		end
		else if (a == `CTOTR_ADDR_T1_SINGLE_IN2)
		begin
			r = {1'b1, `CTOTR_IDX_T1_SINGLE_IN2};
		end
		else if (a == `CTOTR_ADDR_T2_SINGLE_IN2)
		begin
			r = {1'b1, `CTOTR_IDX_T2_SINGLE_IN2};
		end
		else if (even == `CTOTR_ADDR_O1_DUAL_IN1)
		begin
			r = {1'b1, `CTOTR_IDX_O1_DUAL_IN1 + {3'h0, a[0]}};
		end
		else if (even == `CTOTR_ADDR_O1_DUAL_IN2)
		begin
			r = {1'b1, `CTOTR_IDX_O1_DUAL_IN2 + {3'h0, a[0]}};
		end
		else if (even == `CTOTR_ADDR_O1_SINGLE_IN1)
		begin
			r = {1'b1, `CTOTR_IDX_O1_SINGLE_IN1 + {3'h0, a[0]}};
		end
		else if (even == `CTOTR_ADDR_O1_SINGLE_IN2)
		begin
			r = {1'b1, `CTOTR_IDX_O1_SINGLE_IN2 + {3'h0, a[0]}};
		end
		else if (even == `CTOTR_ADDR_O2_IN1)
		begin
			r = {1'b1, `CTOTR_IDX_O2_IN1 + {3'h0, a[0]}};
		end
		return r;
	endfunction

	// Twelve-bit offset field from a little-endian byte pair
	function automatic logic [`CTOTR_OFFSET_MSB:0] offset_of(
		input logic [`CTOTR_FUSE_BYTES-1:0][7:0] m,
		input ctotr_idx_t                         lo);
		ctotr_idx_t  hi;
		logic [15:0] w;
		hi = lo + 4'h1;
		w = {m[hi], m[lo]};
		// Reserved top nibble is stored for readback only
		return w[`CTOTR_OFFSET_MSB:0];
	endfunction

	logic [4:0] hit;

	always_comb
	begin
		next_s = s;
		hit = map_addr(reg_addr_i);
		next_s.busy = ld_busy;
		next_s.rvalid = reg_rd_i;
		next_s.rdata = `CTOTR_UNMAPPED_READ;

		if (reg_rd_i && hit[4])
		begin
			next_s.rdata = s.mem[hit[3:0]];
		end

		if (ld_we)
		begin
			next_s.mem[ld_idx] = ld_data;
		end
		else if (reg_wr_i && hit[4] && !ld_busy)
		begin
			next_s.mem[hit[3:0]] = reg_wdata_i;
		end

		next_s.t1 = `CTOTR_RESET_BYTE;
		next_s.t2 = `CTOTR_RESET_BYTE;
		next_s.o1 = '0;
		next_s.o2 = '0;
		if (fg_cal_en_i)
		begin
			if (!dual_mode_i)
			begin
				if (core_one_in2_i)
				begin
					next_s.t1 = s.mem[`CTOTR_IDX_T1_SINGLE_IN2];
				end
				if (core_two_in2_i)
				begin
					next_s.t2 = s.mem[`CTOTR_IDX_T2_SINGLE_IN2];
				end
				else
				begin
					next_s.t2 = s.mem[`CTOTR_IDX_T2_SINGLE_IN1];
				end
			end
			if (dual_mode_i && !core_one_in2_i)
			begin
				next_s.o1 = offset_of(s.mem, `CTOTR_IDX_O1_DUAL_IN1);
			end
			else if (dual_mode_i)
			begin
				next_s.o1 = offset_of(s.mem, `CTOTR_IDX_O1_DUAL_IN2);
			end
			else if (!core_one_in2_i)
			begin
				next_s.o1 = offset_of(s.mem, `CTOTR_IDX_O1_SINGLE_IN1);
			end
			else
			begin
				next_s.o1 = offset_of(s.mem, `CTOTR_IDX_O1_SINGLE_IN2);
			end
			if (!core_two_in2_i)
			begin
				next_s.o2 = offset_of(s.mem, `CTOTR_IDX_O2_IN1);
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			// Busy from reset so fuse_busy_o reports busy before the fuse walk starts
			s <= '0;
			s.busy <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign reg_rdata_o       = s.rdata;
	assign reg_rvalid_o      = s.rvalid;
	assign fuse_busy_o       = s.busy;
	assign core_one_timing_o = s.t1;
	assign core_two_timing_o = s.t2;
	assign core_one_offset_o = s.o1;
	assign core_two_offset_o = s.o2;
endmodule

// *** rtl/ctotr_cfg.svh ***
// Addresses, field positions, reset values and counts for the core trim register bank
`ifndef CTOTR_CFG_SVH
`define CTOTR_CFG_SVH

`define CTOTR_ADDR_W             15
`define CTOTR_ADDR_T2_SINGLE_IN1 15'h315
`define CTOTR_ADDR_T1_SINGLE_IN2 15'h31A
`define CTOTR_ADDR_T2_SINGLE_IN2 15'h31B
`define CTOTR_ADDR_O1_DUAL_IN1   15'h344
`define CTOTR_ADDR_O1_DUAL_IN2   15'h346
`define CTOTR_ADDR_O1_SINGLE_IN1 15'h348
`define CTOTR_ADDR_O1_SINGLE_IN2 15'h34A
`define CTOTR_ADDR_O2_IN1        15'h34C
`define CTOTR_OFFSET_MSB         11
`define CTOTR_RESET_BYTE         8'h00
`define CTOTR_UNMAPPED_READ      8'h00
`define CTOTR_FUSE_BYTES         13
`define CTOTR_FUSE_LAST          4'hC
`define CTOTR_IDX_T2_SINGLE_IN1  4'h0
`define CTOTR_IDX_T1_SINGLE_IN2  4'h1
`define CTOTR_IDX_T2_SINGLE_IN2  4'h2
`define CTOTR_IDX_O1_DUAL_IN1    4'h3
`define CTOTR_IDX_O1_DUAL_IN2    4'h5
`define CTOTR_IDX_O1_SINGLE_IN1  4'h7
`define CTOTR_IDX_O1_SINGLE_IN2  4'h9
`define CTOTR_IDX_O2_IN1         4'hB

`endif

// *** rtl/ctotr_pkg.sv ***
// Types shared by the core trim register bank
package ctotr_pkg;
	typedef enum logic [0:0] {
		CTOTR_LD_RUN,
		CTOTR_LD_DONE
	} ctotr_ld_state_t;

	typedef logic [3:0] ctotr_idx_t;
	typedef logic [7:0] ctotr_byte_t;
endpackage

// *** rtl/ctotr_fuse_loader.sv ***
// Walks factory fuse storage after reset and hands each byte to the bank
`timescale 1ns/100ps
`include "ctotr_cfg.svh"
module ctotr_fuse_loader
(
	input  wire logic                  clock_i,
	input  wire logic                  rst_b_i,
	input  wire ctotr_pkg::ctotr_byte_t fuse_data_i,
	output logic [3:0]                 fuse_addr_o,
	output logic                       ld_we_o,
	output ctotr_pkg::ctotr_idx_t      ld_idx_o,
	output ctotr_pkg::ctotr_byte_t     ld_data_o,
	output logic                       busy_o
);
	import ctotr_pkg::*;

	typedef struct packed {
		ctotr_ld_state_t state;
		ctotr_idx_t      idx;
		logic            pend;
		ctotr_idx_t      pend_idx;
	} ctotr_ld_t;

	ctotr_ld_t s;
	ctotr_ld_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.pend = 1'b0;
		case (s.state)
			CTOTR_LD_RUN:
			begin
				// Fuse byte arrives one cycle after its address
				next_s.pend = 1'b1;
				next_s.pend_idx = s.idx;
				if (s.idx == `CTOTR_FUSE_LAST)
				begin
					next_s.state = CTOTR_LD_DONE;
				end
				else
				begin
					next_s.idx = s.idx + 4'h1;
				end
			end
			default:
			begin
				next_s.state = CTOTR_LD_DONE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s <= '{CTOTR_LD_RUN, 4'h0, 1'b0, 4'h0};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign fuse_addr_o = s.idx;
	assign ld_we_o     = s.pend;
	assign ld_idx_o    = s.pend_idx;
	assign ld_data_o   = fuse_data_i;
	assign busy_o      = (s.state == CTOTR_LD_RUN) || s.pend;
endmodule

// *** dv/ctotr_bank_checker.sv ***
// Port checker for the core trim register bank
`timescale 1ns/100ps
module ctotr_checker
(
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic [3:0]  fuse_addr_o,
	input wire logic        fuse_busy_o,
	input wire logic        dual_mode_i,
	input wire logic        fg_cal_en_i,
	input wire logic        core_one_in2_i,
	input wire logic        core_two_in2_i,
	input wire logic [7:0]  core_one_timing_o,
	input wire logic [7:0]  core_two_timing_o,
	input wire logic [11:0] core_two_offset_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (!rst_b_i);
sequence s_load_done;
	##[1:20] !fuse_busy_o;
endsequence
AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
	else $error("read not answered");
AST_IDLE: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
	else $error("read data without read");
AST_CALOFF: assert property (!fg_cal_en_i |=> core_one_timing_o == 8'h00 &&
	core_two_timing_o == 8'h00 && core_two_offset_o == 12'h000) else $error("trim with cal off");
AST_DUALT: assert property (dual_mode_i |=> core_two_timing_o == 8'h00)
	else $error("single timing in dual mode");
AST_T1IN1: assert property (!dual_mode_i && !core_one_in2_i |=> core_one_timing_o == 8'h00)
	else $error("core one timing on first input");
AST_O2IN2: assert property (core_two_in2_i |=> core_two_offset_o == 12'h000)
	else $error("core two offset on second input");
AST_FSTEP: assert property ($changed(fuse_addr_o) |-> fuse_addr_o == $past(fuse_addr_o) + 4'h1)
	else $error("fuse index skipped");
AST_LOAD: assert property (fuse_busy_o && fuse_addr_o == 4'h0 |-> s_load_done)
	else $error("fuse load too long");
endmodule
bind ctotr_bank ctotr_checker u_chk
(
	.clock_i           (clock_i),
	.rst_b_i           (rst_b_i),
	.reg_rd_i          (reg_rd_i),
	.reg_rdata_o       (reg_rdata_o),
	.reg_rvalid_o      (reg_rvalid_o),
	.fuse_addr_o       (fuse_addr_o),
	.fuse_busy_o       (fuse_busy_o),
	.dual_mode_i       (dual_mode_i),
	.fg_cal_en_i       (fg_cal_en_i),
	.core_one_in2_i    (core_one_in2_i),
	.core_two_in2_i    (core_two_in2_i),
	.core_one_timing_o (core_one_timing_o),
	.core_two_timing_o (core_two_timing_o),
	.core_two_offset_o (core_two_offset_o)
);

// *** dv/test_core_timing_offset_trim_regs.sv ***
// Self-checking bench for the core trim register bank
`timescale 1ns/100ps
module test_core_timing_offset_trim_regs;
import ctotr_pkg::*;
logic clock_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, dual_mode_i = 0, fg_cal_en_i = 0;
logic core_one_in2_i = 0, core_two_in2_i = 0, on = 0, reg_rvalid_o, fuse_busy_o;
logic [14:0] reg_addr_i = 0;
logic [3:0] fuse_addr_o;
logic [11:0] core_one_offset_o, core_two_offset_o, eo1, eo2;
ctotr_byte_t reg_wdata_i = 0, fuse_data_i, reg_rdata_o, core_one_timing_o, core_two_timing_o;
ctotr_byte_t e1, e2, fz [13], m [int];
int errors = 0, check_count = 0, cyc = 0, seed = 32'h810D, k, j, oa;
int map [13] = '{'h315, 'h31A, 'h31B, 'h344, 'h345, 'h346, 'h347, 'h348, 'h349, 'h34A, 'h34B,
	'h34C, 'h34D};
always #5 clock_i = ~clock_i;
// Fuse storage is registered: the byte follows its index by one cycle
always @(posedge clock_i)
	fuse_data_i <= fz[fuse_addr_o];
ctotr_bank dut_u
(
	.clock_i           (clock_i),
	.rst_b_i           (rst_b_i),
	.reg_addr_i        (reg_addr_i),
	.reg_wr_i          (reg_wr_i),
	.reg_wdata_i       (reg_wdata_i),
	.reg_rd_i          (reg_rd_i),
	.reg_rdata_o       (reg_rdata_o),
	.reg_rvalid_o      (reg_rvalid_o),
	.fuse_data_i       (fuse_data_i),
	.fuse_addr_o       (fuse_addr_o),
	.fuse_busy_o       (fuse_busy_o),
	.dual_mode_i       (dual_mode_i),
	.fg_cal_en_i       (fg_cal_en_i),
	.core_one_in2_i    (core_one_in2_i),
	.core_two_in2_i    (core_two_in2_i),
	.core_one_timing_o (core_one_timing_o),
	.core_two_timing_o (core_two_timing_o),
	.core_one_offset_o (core_one_offset_o),
	.core_two_offset_o (core_two_offset_o)
);
task automatic chk(string n, logic [31:0] s, logic [31:0] e);
	check_count++;
	if (s !== e)
	begin
		$display("[ERR] %s exp %h seen %h", n, e, s);
		errors++;
	end
endtask
function logic [11:0] w16(int a);
	return {m[a + 1][3:0], m[a]};
endfunction
task stop_test;
	$display("checks %0d errors %0d", check_count, errors);
	if (errors == 0 && check_count > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
task acc(logic w, int a, ctotr_byte_t d);
	@(posedge clock_i);
	reg_addr_i <= a[14:0];
	reg_wr_i <= w;
	reg_rd_i <= !w;
	reg_wdata_i <= d;
	{dual_mode_i, fg_cal_en_i, core_one_in2_i, core_two_in2_i} <= 4'($random(seed));
	@(posedge clock_i);
	reg_wr_i <= 0;
	reg_rd_i <= 0;
	if (w && !fuse_busy_o)
		m[a] = d;
	#1;
	chk("rvalid", reg_rvalid_o, !w);
	if (!w)
		chk("rdata", reg_rdata_o, m.exists(a) ? m[a] : 0);
endtask
task load;
	for (k = 0; k < 30 && fuse_busy_o !== 0; k++)
		@(posedge clock_i);
	chk("busy", fuse_busy_o, 0);
	chk("fidx", fuse_addr_o, 12);
	foreach (fz[i])
		m[map[i]] = fz[i];
	on = 1;
	foreach (map[i])
		acc(0, map[i], 0);
endtask
// Expected trims from the model, compared after the next edge
always @(negedge clock_i)
begin
	if (on)
	begin
		e1 = (fg_cal_en_i && !dual_mode_i && core_one_in2_i) ? m['h31A] : 0;
		e2 = (fg_cal_en_i && !dual_mode_i) ? m[core_two_in2_i ? 'h31B : 'h315] : 0;
		oa = dual_mode_i ? (core_one_in2_i ? 'h346 : 'h344) : (core_one_in2_i ? 'h34A : 'h348);
		eo1 = fg_cal_en_i ? w16(oa) : 0;
		eo2 = (fg_cal_en_i && !core_two_in2_i) ? w16('h34C) : 0;
		@(posedge clock_i) #1;
		chk("t1", core_one_timing_o, e1);
		chk("t2", core_two_timing_o, e2);
		chk("o1", core_one_offset_o, eo1);
		chk("o2", core_two_offset_o, eo2);
	end
end
always @(posedge clock_i)
begin
	cyc++;
	if (cyc == 2000)
	begin
		errors++;
		stop_test;
	end
end
initial
begin
	foreach (fz[i])
		fz[i] = 8'($random(seed));
	repeat (5) @(posedge clock_i);
	rst_b_i <= 1;
	load;
	for (j = 0; j < 80; j++)
		acc(j % 2 == 0, map[(32'($random(seed)) & 32'hFF) % 13], 8'($random(seed)));
	acc(0, 'h310, 0);
	acc(0, 'h34E, 0);
	on = 0;
	@(posedge clock_i) rst_b_i <= 0;
	@(posedge clock_i) rst_b_i <= 1;
	// Write after byte 0 is stored but while still loading is dropped
	repeat (3) @(posedge clock_i);
	acc(1, 'h315, ~fz[0]);
	load;
	stop_test;
end
endmodule
